// *** design/test_pin_io.sv ***
`timescale 1ns/1ps
module test_pin_io
    import test_pin_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [5:0]       addr_i,
    input  wire logic [7:0]       wr_data_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rd_data_o,
    input  wire host_if_t         host_if_i,
    input  wire logic [6:0]       pin_in_i,
    output logic      [6:0]       pin_out_o,
    output logic      [6:0]       pin_oe_o,
    output logic                  uart_mode_line_en_o,
    output logic                  uart_request_line_en_o,
    output logic                  secure_clock_on_pin1_o,
    input  wire logic [255:0]     test_buses_i,
    output logic      [4:0]       probe_bus_select_o,
    output logic                  receiver_nonlinear_o,
    output delimiter_t            delimiter_o,
    input  wire logic             self_test_cmd_i,
    output logic                  self_test_enable_o,
    output logic                  self_test_start_o
);

    logic [7:0] pin_drv_en_reg;
    logic [7:0] pin_io_val_reg;
    logic [7:0] self_test_reg;
    logic [7:0] test_sel1_reg;
    logic [7:0] test_sel2_reg;
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [6:0] pin_s3_reg;
    logic [6:0] pin_level_reg;
    logic       serial_host;
    logic [6:0] io_mask;
    logic [6:0] oe_next;
    logic [7:0] rd_next;
    logic [7:0] bus_view;
    delimiter_t delim_next;

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_drv_en_reg <= RST_PIN_DRV_EN;
        end else if (wr_i && addr_i == OFS_PIN_DRV_EN) begin
            pin_drv_en_reg <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_io_val_reg <= RST_PIN_IO_VAL;
        end else if (wr_i && addr_i == OFS_PIN_IO_VAL) begin
            pin_io_val_reg <= wr_data_i;
        end
    end

    // Bit 7 is kept for production test and bit 4 is unused; both read zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            self_test_reg <= RST_SELF_TEST;
        end else if (wr_i && addr_i == OFS_SELF_TEST) begin
            self_test_reg <= wr_data_i & 8'h6f;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            test_sel1_reg <= RST_TEST_SEL;
            test_sel2_reg <= RST_TEST_SEL;
        end else if (wr_i && addr_i == OFS_TEST_SEL1) begin
            test_sel1_reg <= wr_data_i;
        end else if (wr_i && addr_i == OFS_TEST_SEL2) begin
            test_sel2_reg <= wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling: a level counts once the second and third stages agree

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_reg    <= 7'h00;
            pin_s2_reg    <= 7'h00;
            pin_s3_reg    <= 7'h00;
            pin_level_reg <= 7'h00;
        end else begin
            pin_s1_reg    <= pin_in_i;
            pin_s2_reg    <= pin_s1_reg;
            pin_s3_reg    <= pin_s2_reg;
            for (int i = 0; i < 7; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_level_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Which data pins may serve as I/O

    assign serial_host = (host_if_i != HOST_PARALLEL);

    always_comb begin
        io_mask = MASK_ALL_PINS;
        if (host_if_i == HOST_SPI) begin
            io_mask = MASK_LOW_PINS;
        end
        if (host_if_i == HOST_UART && pin_drv_en_reg[BIT_HANDSHAKE]) begin
            io_mask = MASK_LOW_PINS;
        end
        if (test_sel1_reg[BIT_SECURE_CLK]) begin
            io_mask[PIN_SECURE_CLK] = 1'b0;
        end
        // Driver on only in I/O mode, under a serial host, where enabled
        oe_next = (pin_io_val_reg[BIT_IO_USE] && serial_host)
                ? (pin_drv_en_reg[6:0] & io_mask)
                : 7'h00;
    end

    // Registered so the pads never see decode glitches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_oe_o  <= 7'h00;
            pin_out_o <= 7'h00;
        end else begin
            pin_oe_o  <= oe_next;
            pin_out_o <= pin_io_val_reg[6:0] & oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Side controls

    always_comb begin
        delim_next.sof_low  = SOF_LOW_MIN;
        delim_next.sof_high = SOF_HIGH_MIN;
        delim_next.eof_low  = SOF_LOW_MIN;
        if (self_test_reg[BIT_DELIM_ADJ] && pin_drv_en_reg[5]) begin
            delim_next.sof_low  = SOF_LOW_ADJ;
            delim_next.sof_high = SOF_HIGH_ADJ;
            delim_next.eof_low  = SOF_LOW_ADJ;
        end else if (!self_test_reg[BIT_DELIM_ADJ] && pin_drv_en_reg[5]) begin
            delim_next.sof_low  = SOF_LOW_MAX;
            delim_next.sof_high = SOF_HIGH_MAX;
            delim_next.eof_low  = SOF_LOW_MAX;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uart_mode_line_en_o    <= 1'b1;
            uart_request_line_en_o <= 1'b1;
            secure_clock_on_pin1_o <= 1'b0;
            probe_bus_select_o     <= 5'h00;
            receiver_nonlinear_o   <= 1'b1;
            delimiter_o            <= '0;
            self_test_enable_o     <= 1'b0;
            self_test_start_o      <= 1'b0;
        end else begin
            uart_mode_line_en_o    <= pin_drv_en_reg[BIT_HANDSHAKE];
            uart_request_line_en_o <= pin_drv_en_reg[BIT_HANDSHAKE];
            // Pin 1 carries the clock only when its select bit is set and a serial host is selected
            secure_clock_on_pin1_o <= test_sel1_reg[BIT_SECURE_CLK] && serial_host;
            probe_bus_select_o     <= test_sel2_reg[4:0];
            receiver_nonlinear_o   <= self_test_reg[BIT_NONLINEAR];
            delimiter_o            <= delim_next;
            self_test_enable_o     <= (self_test_reg[3:0] == SELF_TEST_ON);
            self_test_start_o      <= self_test_cmd_i
                                      && (self_test_reg[3:0] == SELF_TEST_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    assign bus_view = test_buses_i[{test_sel2_reg[4:0], 3'h0} +: 8];

    always_comb begin
        case (addr_i)
            OFS_TEST_SEL1:  rd_next = test_sel1_reg;
            OFS_TEST_SEL2:  rd_next = test_sel2_reg;
            OFS_PIN_DRV_EN: rd_next = pin_drv_en_reg;
            OFS_PIN_IO_VAL: rd_next = pin_io_val_reg[BIT_IO_USE]
                                    ? {1'b1, pin_level_reg}
                                    : pin_io_val_reg;
            OFS_TEST_BUS:   rd_next = bus_view;
            OFS_SELF_TEST:  rd_next = self_test_reg;
            default:        rd_next = 8'h00;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rd_i ? rd_next : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    handshake_off_a: assert property (
        !pin_drv_en_reg[BIT_HANDSHAKE] |=> !uart_mode_line_en_o && !uart_request_line_en_o)
        else $error("handshake lines active while disabled");

    parallel_quiet_a: assert property (
        host_if_i == HOST_PARALLEL |=> pin_oe_o == 7'h00)
        else $error("pin driven under parallel host");

    spi_upper_a: assert property (
        host_if_i == HOST_SPI |=> pin_oe_o[6:5] == 2'b00)
        else $error("upper pin driven under spi");

    uart_upper_a: assert property (
        host_if_i == HOST_UART && pin_drv_en_reg[BIT_HANDSHAKE] |=> pin_oe_o[6:5] == 2'b00)
        else $error("upper pin driven under uart with handshake");

    drive_enable_a: assert property (
        serial_host && pin_io_val_reg[BIT_IO_USE] && host_if_i == HOST_I2C
        && !test_sel1_reg[BIT_SECURE_CLK] |=> pin_oe_o == $past(pin_drv_en_reg[6:0]))
        else $error("driver enables not followed");

    pin_level_a: assert property (
        1'b1 |=> (pin_out_o & ~pin_oe_o) == 7'h00
        && (pin_out_o & pin_oe_o) == ($past(pin_io_val_reg[6:0]) & pin_oe_o))
        else $error("pin level differs from value bits");

    secure_pin_a: assert property (
        test_sel1_reg[BIT_SECURE_CLK] |=> !pin_oe_o[PIN_SECURE_CLK])
        else $error("pin 1 driven while carrying secure clock");

    readback_a: assert property (
        rd_i && addr_i == OFS_PIN_IO_VAL && !pin_io_val_reg[BIT_IO_USE]
        |=> rd_data_o == $past(pin_io_val_reg))
        else $error("stored value not read back");

    sampled_read_a: assert property (
        rd_i && addr_i == OFS_PIN_IO_VAL && pin_io_val_reg[BIT_IO_USE]
        |=> rd_data_o == {1'b1, $past(pin_level_reg)})
        else $error("pin levels not read back");

    bus_view_a: assert property (
        rd_i && addr_i == OFS_TEST_BUS
        |=> rd_data_o == $past(test_buses_i[{test_sel2_reg[4:0], 3'h0} +: 8]))
        else $error("test bus view wrong");

    self_test_a: assert property (
        self_test_cmd_i && self_test_reg[3:0] != SELF_TEST_ON |=> !self_test_start_o)
        else $error("self test started while disabled");

    delim_adj_a: assert property (
        self_test_reg[BIT_DELIM_ADJ] && pin_drv_en_reg[5]
        |=> delimiter_o.sof_low == SOF_LOW_ADJ && delimiter_o.sof_high == SOF_HIGH_ADJ
        && delimiter_o.eof_low == SOF_LOW_ADJ)
        else $error("adjusted delimiter lengths wrong");

    ////////////////////////////////////////////////////////////////////////
    // Side controls, pin drivers, pin sampling and register storage

    delim_max_a: assert property (
        !self_test_reg[BIT_DELIM_ADJ] && pin_drv_en_reg[5]
        |=> delimiter_o.sof_low == SOF_LOW_MAX && delimiter_o.sof_high == SOF_HIGH_MAX
        && delimiter_o.eof_low == SOF_LOW_MAX)
        else $error("maximum delimiter lengths wrong");

    delim_min_a: assert property (
        !pin_drv_en_reg[5]
        |=> delimiter_o.sof_low == SOF_LOW_MIN && delimiter_o.sof_high == SOF_HIGH_MIN
        && delimiter_o.eof_low == SOF_LOW_MIN)
        else $error("minimum delimiter lengths wrong");

    receiver_mode_a: assert property (
        1'b1 |=> receiver_nonlinear_o == $past(self_test_reg[BIT_NONLINEAR]))
        else $error("receiver mode does not follow its bit");

    handshake_on_a: assert property (
        pin_drv_en_reg[BIT_HANDSHAKE] |=> uart_mode_line_en_o && uart_request_line_en_o)
        else $error("handshake lines off while enabled");

    probe_select_a: assert property (
        1'b1 |=> probe_bus_select_o == $past(test_sel2_reg[4:0]))
        else $error("probe select does not follow its field");

    // The clock route is refused while the parallel host owns pin 1
    secure_route_a: assert property (
        1'b1 |=> secure_clock_on_pin1_o == $past(test_sel1_reg[BIT_SECURE_CLK] && serial_host))
        else $error("secure clock route wrong");

    self_enable_a: assert property (
        1'b1 |=> self_test_enable_o == ($past(self_test_reg[3:0]) == SELF_TEST_ON))
        else $error("self test enable wrong");

    io_off_a: assert property (
        !pin_io_val_reg[BIT_IO_USE] |=> pin_oe_o == 7'h00)
        else $error("pin driven outside io mode");

    undriven_input_a: assert property (
        1'b1 |=> (pin_oe_o & ~$past(pin_drv_en_reg[6:0])) == 7'h00)
        else $error("pin driven without its driver enable");

    drv_en_write_a: assert property (
        wr_i && addr_i == OFS_PIN_DRV_EN |=> pin_drv_en_reg == $past(wr_data_i))
        else $error("driver enable write lost");

    // Reserved bits must stay zero or the self-test code could be misread
    self_write_a: assert property (
        wr_i && addr_i == OFS_SELF_TEST |=> self_test_reg == ($past(wr_data_i) & 8'h6f))
        else $error("self test control write wrong");

    pin_sample_a: assert property (
        pin_s2_reg == pin_s3_reg |=> pin_level_reg == $past(pin_s3_reg))
        else $error("agreed pin level not taken");

    view_readonly_a: assert property (
        wr_i && addr_i == OFS_TEST_BUS
        |=> $stable(pin_drv_en_reg) && $stable(pin_io_val_reg) && $stable(self_test_reg))
        else $error("write to test bus view changed a register");

    io_mode_c:    cover property (pin_oe_o != 7'h00);
    io_read_c:    cover property (rd_i && addr_i == OFS_PIN_IO_VAL && pin_io_val_reg[7]);
    self_test_c:  cover property (self_test_start_o);
    secure_clk_c: cover property (secure_clock_on_pin1_o);
    delim_adj_c:  cover property (self_test_reg[BIT_DELIM_ADJ] && pin_drv_en_reg[5]);

endmodule

// *** design/test_pin_pkg.sv ***
package test_pin_pkg;

    localparam logic [5:0] OFS_TEST_SEL1   = 6'h31;
    localparam logic [5:0] OFS_TEST_SEL2   = 6'h32;
    localparam logic [5:0] OFS_PIN_DRV_EN  = 6'h33;
    localparam logic [5:0] OFS_PIN_IO_VAL  = 6'h34;
    localparam logic [5:0] OFS_TEST_BUS    = 6'h35;
    localparam logic [5:0] OFS_SELF_TEST   = 6'h36;

    localparam logic [7:0] RST_PIN_DRV_EN  = 8'h80;
    localparam logic [7:0] RST_PIN_IO_VAL  = 8'h00;
    localparam logic [7:0] RST_SELF_TEST   = 8'h40;
    localparam logic [7:0] RST_TEST_SEL    = 8'h00;

    localparam int BIT_HANDSHAKE   = 7;
    localparam int BIT_IO_USE      = 7;
    localparam int BIT_NONLINEAR   = 6;
    localparam int BIT_DELIM_ADJ   = 5;
    localparam int BIT_SECURE_CLK  = 3;
    localparam int PIN_SECURE_CLK  = 1;
    localparam logic [3:0] SELF_TEST_ON  = 4'h9;
    localparam logic [3:0] SELF_TEST_OFF = 4'h0;

    // Pins usable as I/O: all seven, or pins 0 to 4 when the serial link keeps the upper data pins
    localparam logic [6:0] MASK_ALL_PINS = 7'h7f;
    localparam logic [6:0] MASK_LOW_PINS = 7'h1f;

    // Delimiter timing, in carrier cycles; one etu is 128 cycles at 106 kbit
    localparam int ETU_CYCLES      = 128;
    localparam int ADJ_CYCLES      = 8;
    localparam logic [11:0] SOF_LOW_MIN  = 12'(10 * ETU_CYCLES);
    localparam logic [11:0] SOF_LOW_MAX  = 12'(11 * ETU_CYCLES);
    localparam logic [11:0] SOF_HIGH_MIN = 12'(2 * ETU_CYCLES);
    localparam logic [11:0] SOF_HIGH_MAX = 12'(3 * ETU_CYCLES);
    localparam logic [11:0] SOF_LOW_ADJ  = 12'(11 * ETU_CYCLES - ADJ_CYCLES);
    localparam logic [11:0] SOF_HIGH_ADJ = 12'(2 * ETU_CYCLES + ADJ_CYCLES);

    typedef enum logic [1:0] {
        HOST_PARALLEL = 2'h0,
        HOST_SPI      = 2'h1,
        HOST_UART     = 2'h3,
        HOST_I2C      = 2'h2
    } host_if_t;

    typedef struct packed {
        logic [11:0] sof_low;
        logic [11:0] sof_high;
        logic [11:0] eof_low;
    } delimiter_t;

endpackage

// *** tb/pin_far_end.sv ***
`timescale 1ns/1ps
module pin_far_end (
    input  wire logic [6:0] pin_out_i,
    input  wire logic [6:0] pin_oe_i,
    input  wire logic [6:0] ext_level_i,
    output logic      [6:0] pad_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Outside circuitry holds every pin that the device releases, so an undriven
    // pin shows the outside level and never a stale device value
    always_comb begin
        for (int n = 0; n < 7; n++) begin
            pad_o[n] = pin_oe_i[n] ? pin_out_i[n] : ext_level_i[n];
        end
    end
endmodule

// *** tb/test_pin_io_tb.sv ***
`timescale 1ns/1ps
module test_pin_io_tb;
    import test_pin_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, cmd = 1'b0, rd_seen = 1'b0;
    logic [5:0]   addr_i = 6'h00;
    logic [7:0]   wr_data_i = 8'h00, rd_data_o, en, val, s1;
    host_if_t     host_if_i = HOST_PARALLEL;
    logic [6:0]   pad, pin_out, pin_oe, ext, ext_lvl = 7'h00, m, e_oe;
    logic [255:0] buses = '0, bus;
    logic         mode_en, req_en, sclk, nonlin, st_en, st_go;
    logic [4:0]   probe_sel;
    delimiter_t   delim;
    logic [7:0]   exp_q[$];
    int           error_cnt = 0, n_checks = 0, cyc = 0;
    integer       seed = 32'h58138940;

    always #50 clk_i = ~clk_i;

    test_pin_io dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .host_if_i(host_if_i), .pin_in_i(pad), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .uart_mode_line_en_o(mode_en), .uart_request_line_en_o(req_en),
        .secure_clock_on_pin1_o(sclk), .test_buses_i(buses),
        .probe_bus_select_o(probe_sel), .receiver_nonlinear_o(nonlin),
        .delimiter_o(delim), .self_test_cmd_i(cmd), .self_test_enable_o(st_en),
        .self_test_start_o(st_go));

    pin_far_end far_u (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_level_i(ext_lvl),
        .pad_o(pad));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        chk(36'(got), 36'(exp));
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // The expected byte is queued before the strobe, the watcher below takes it
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        exp_q.push_back(exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stand for one cycle only, so every other cycle must read 0
    always @(posedge clk_i) rd_seen <= rd_i;
    always @(negedge clk_i) begin
        if (rd_seen) chk_rd(rd_data_o, exp_q.pop_front());
        else chk_rd(rd_data_o, 8'h00);
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk(36'({mode_en, req_en, nonlin}), 36'h7);
        // Delimiter lengths hold zero in reset and take their value one edge later
        @(posedge clk_i);
        #1;
        chk(36'(delim), {12'd1280, 12'd256, 12'd1280});
        rd(OFS_PIN_DRV_EN, 8'h80);
        rd(OFS_PIN_IO_VAL, 8'h00);
        rd(OFS_SELF_TEST, 8'h40);
        rd(OFS_TEST_SEL1, 8'h00);
        rd(OFS_TEST_SEL2, 8'h00);
        rd(6'h30, 8'h00);
        rd(6'h37, 8'h00);
        wr(OFS_SELF_TEST, 8'hff);
        rd(OFS_SELF_TEST, 8'h6f);
        // Every host mode, random enables, levels and secure clock routing
        for (int h = 0; h < 4; h++) begin
            for (int k = 0; k < 12; k++) begin
                en = $random(seed);
                val = $random(seed);
                s1 = $random(seed);
                ext = $random(seed);
                host_if_i <= host_if_t'(h[1:0]);
                ext_lvl <= ext;
                wr(OFS_TEST_SEL1, s1);
                wr(OFS_PIN_DRV_EN, en);
                wr(OFS_PIN_IO_VAL, val);
                repeat (8) @(posedge clk_i);
                #1;
                m = 7'h7f;
                if (h == 1 || (h == 3 && en[7])) m = 7'h1f;
                if (s1[3]) m[1] = 1'b0;
                e_oe = (val[7] && h != 0) ? (en[6:0] & m) : 7'h00;
                chk(36'(pin_oe), 36'(e_oe));
                chk(36'(pin_out), 36'(val[6:0] & e_oe));
                chk(36'({mode_en, req_en}), 36'({2{en[7]}}));
                chk(36'(sclk), 36'(s1[3] && h != 0));
                rd(OFS_PIN_IO_VAL, val[7] ? {1'b1, (e_oe & val[6:0]) | (~e_oe & ext)} : val);
            end
        end
        // Bus view follows the select field; a write to it changes nothing
        for (int k = 0; k < 8; k++) begin
            s1 = $random(seed);
            if (k == 0) s1[4:0] = 5'h1f;
            for (int j = 0; j < 8; j++) bus[32*j +: 32] = $random(seed);
            buses <= bus;
            wr(OFS_TEST_SEL2, s1);
            wr(OFS_TEST_BUS, ~s1);
            repeat (3) @(posedge clk_i);
            #1;
            chk(36'(probe_sel), 36'(s1[4:0]));
            rd(OFS_TEST_BUS, bus[8*s1[4:0] +: 8]);
        end
        // Delimiter lengths: minimum, maximum, adjusted
        for (int d = 0; d < 3; d++) begin
            wr(OFS_PIN_DRV_EN, {2'b10, d != 0, 5'h00});
            wr(OFS_SELF_TEST, {1'b0, d[0], d == 2, 5'h00});
            repeat (3) @(posedge clk_i);
            #1;
            chk(36'(nonlin), 36'(d[0]));
            chk(36'(delim), (d == 0) ? {12'd1280, 12'd256, 12'd1280} :
                (d == 1) ? {12'd1408, 12'd384, 12'd1408} :
                {12'd1400, 12'd264, 12'd1400});
        end
        // Self-test runs on the command only with the enabling code
        for (int f = 0; f < 2; f++) begin
            wr(OFS_SELF_TEST, f ? 8'h49 : 8'h48);
            repeat (3) @(posedge clk_i);
            #1;
            chk(36'(st_en), 36'(f));
            @(posedge clk_i);
            cmd <= 1'b1;
            @(posedge clk_i);
            cmd <= 1'b0;
            #1;
            chk(36'(st_go), 36'(f));
            @(posedge clk_i);
            #1;
            chk(36'(st_go), 36'h0);
        end
        wr(OFS_SELF_TEST, 8'h40);
        repeat (3) @(posedge clk_i);
        #1;
        chk(36'(st_en), 36'h0);
        end_of_test();
    end
endmodule
